// [design/drg_pkg.sv]
// drg_pkg: constants, map and helper functions for the dma region guard
// assumes: 32-bit byte addresses, 8 KB paged regions, 3-bit process ids
package drg_pkg;

   // ----------------------------------------------------------------------
   // dma permission map
   // ----------------------------------------------------------------------
   localparam logic [31:0] DRG_DMA_BASE   = 32'h3FFA_E000;
   localparam logic [31:0] DRG_DMA_TOP    = 32'h3FFF_FFFF;
   localparam int          DRG_BLK_SHIFT  = 13;    // 8 KB blocks
   localparam int          DRG_IDX_MSB    = 18;    // offset bits holding idx
   localparam int          DRG_LOW_W      = 32;
   localparam int          DRG_HIGH_W     = 9;
   localparam int          DRG_BLK_CNT    = 41;    // low + high bits
   localparam logic [31:0] DRG_LOW_RST    = 32'h0000_0000;
   localparam logic [8:0]  DRG_HIGH_RST   = 9'h000;

   // ----------------------------------------------------------------------
   // paged code and data banks
   // ----------------------------------------------------------------------
   localparam logic [31:0] DRG_CODE_BASE  = 32'h4008_0000;
   localparam logic [31:0] DRG_CODE_TOP   = 32'h4009_FFFF;
   localparam logic [31:0] DRG_DATA_BASE  = 32'h3FFC_0000;
   localparam logic [31:0] DRG_DATA_TOP   = 32'h3FFD_FFFF;
   localparam int          DRG_PAGE_LSB   = 13;
   localparam int          DRG_PAGE_MSB   = 16;
   localparam int          DRG_PAGE_W     = 4;

   // ----------------------------------------------------------------------
   // process identities
   // ----------------------------------------------------------------------
   localparam int          DRG_PID_W      = 3;
   localparam logic [2:0]  DRG_PRIV_MAX   = 3'h1;

   // ----------------------------------------------------------------------
   // system register port map
   // ----------------------------------------------------------------------
   localparam int          DRG_SRP_AW     = 8;
   localparam logic [7:0]  DRG_OFS_LOW    = 8'h00;
   localparam logic [7:0]  DRG_OFS_HIGH   = 8'h04;
   localparam logic [7:0]  DRG_OFS_STAT   = 8'h08;
   localparam int          DRG_ST_W       = 3;
   localparam int          DRG_ST_DMA     = 0;     // dma denied
   localparam int          DRG_ST_CPU     = 1;     // cpu access denied
   localparam int          DRG_ST_WRREF   = 2;     // write refused
   localparam logic [2:0]  DRG_ST_RST     = 3'h0;

   // inclusive address window test
   function automatic logic drg_in_range(input logic [31:0] addr,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
      return (addr >= lo) && (addr <= hi);
   endfunction : drg_in_range

   // identities 0 and 1 run privileged
   function automatic logic drg_is_priv(input logic [2:0] pid);
      return pid <= DRG_PRIV_MAX;
   endfunction : drg_is_priv

endpackage : drg_pkg

// [design/drg_dma_lookup.sv]
// drg_dma_lookup: maps a dma address onto its permission bit
// assumes: permit vector is {high, low}, block 0 at the lowest address
`timescale 1ns/1ps
module drg_dma_lookup (
   input  wire logic [31:0]                  addr_i,
   input  wire logic [drg_pkg::DRG_BLK_CNT-1:0] permit_i,
   output logic                              in_range_o,
   output logic                              allowed_o
);

   logic [31:0] offset;
   logic [5:0]  idx;

   // ---------------------------------------------------------------------
   // block index
   // ---------------------------------------------------------------------
   // low bits 0..24 data bank, 25..31 and high 0..8 shared bank
   assign offset     = addr_i - drg_pkg::DRG_DMA_BASE;
   assign idx        = offset[drg_pkg::DRG_IDX_MSB:drg_pkg::DRG_BLK_SHIFT];
   assign in_range_o = drg_pkg::drg_in_range(addr_i, drg_pkg::DRG_DMA_BASE,
                                             drg_pkg::DRG_DMA_TOP);

   // only the block bit decides; unguarded space passes untouched
   assign allowed_o  = in_range_o ? permit_i[idx] : 1'b1;

endmodule : drg_dma_lookup

// [design/drg_guard.sv]
// drg_guard: dma region guard and paged ram access check
// assumes: one clock, requests on the same clock, page table looked up
// outside and its verdict and physical page given with each cpu request
//
// Contract
// - code bank over ibus, data bank dbus
// - user ids read only code bank
// - user ids read/write granted data pages
// - ids 0 and 1 get full access
// - one permission bit per 8 KB block
// - dma check ignores process identity
// - set bit allows, cleared bit denies dma
// - low bits 0-24 guard data bank
// - low bits 25-31 guard shared bank
// - high bits 0-8 guard shared bank
// - only ids 0 and 1 write permits
// - permits mapped on system register port
// - ids 0 and 1 map pages flat
`timescale 1ns/1ps
module drg_guard (
   input  wire logic        CORE_CLK_I,
   input  wire logic        SRST_I,
   // system register port
   input  wire logic [7:0]  SRP_ADDR_I,
   input  wire logic        SRP_WR_I,
   input  wire logic        SRP_RD_I,
   input  wire logic [31:0] SRP_WDATA_I,
   input  wire logic [2:0]  SRP_PID_I,
   output logic [31:0]      SRP_RDATA_O,
   output logic             SRP_RVALID_O,
   // dma request
   input  wire logic        DMA_REQ_I,
   input  wire logic [31:0] DMA_ADDR_I,
   input  wire logic        DMA_WE_I,
   output logic             DMA_ACK_O,
   output logic             DMA_START_O,
   output logic             DMA_DENY_O,
   // processor request
   input  wire logic        CPU_REQ_I,
   input  wire logic [31:0] CPU_ADDR_I,
   input  wire logic        CPU_WE_I,
   input  wire logic        CPU_IBUS_I,
   input  wire logic [2:0]  CPU_PID_I,
   input  wire logic        CPU_PAGE_OK_I,
   input  wire logic [3:0]  CPU_MAP_PAGE_I,
   output logic             CPU_ACK_O,
   output logic             CPU_GRANT_O,
   output logic [3:0]       CPU_PHYS_PAGE_O
);

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] permit_low;
      logic [8:0]  permit_high;
      logic [2:0]  status;
      logic [31:0] rdata;
      logic        rvalid;
      logic        dma_ack;
      logic        dma_start;
      logic        cpu_ack;
      logic        cpu_grant;
      logic [3:0]  phys_page;
   } drg_state_s;

   drg_state_s st_q;
   drg_state_s st_d;

   logic                             dma_in_range;
   logic                             dma_allowed;
   logic [drg_pkg::DRG_BLK_CNT-1:0]  permit_vec;
   logic                             in_code;
   logic                             in_data;
   logic                             cpu_priv;
   logic                             srp_priv;
   logic                             bus_ok;
   logic                             cpu_ok;
   logic [3:0]                       cpu_vpage;
   logic                             dma_unused_we;

   // ---------------------------------------------------------------------
   // dma lookup
   // ---------------------------------------------------------------------
   // dma port carries no identity at all, so none can sway the verdict
   assign permit_vec = {st_q.permit_high, st_q.permit_low};
   assign dma_unused_we = DMA_WE_I; // read and write share one verdict

   drg_dma_lookup u_lookup (
      .addr_i     (DMA_ADDR_I),
      .permit_i   (permit_vec),
      .in_range_o (dma_in_range),
      .allowed_o  (dma_allowed)
   );

   // ---------------------------------------------------------------------
   // processor decode
   // ---------------------------------------------------------------------
   assign in_code   = drg_pkg::drg_in_range(CPU_ADDR_I, drg_pkg::DRG_CODE_BASE,
                                            drg_pkg::DRG_CODE_TOP);
   assign in_data   = drg_pkg::drg_in_range(CPU_ADDR_I, drg_pkg::DRG_DATA_BASE,
                                            drg_pkg::DRG_DATA_TOP);
   assign cpu_priv  = drg_pkg::drg_is_priv(CPU_PID_I);
   assign srp_priv  = drg_pkg::drg_is_priv(SRP_PID_I);
   assign cpu_vpage = CPU_ADDR_I[drg_pkg::DRG_PAGE_MSB:drg_pkg::DRG_PAGE_LSB];

   // code bank only on the instruction bus, data bank only on data bus
   assign bus_ok = in_code ? CPU_IBUS_I : (in_data ? !CPU_IBUS_I : 1'b1);

   // access verdict, checked in order of precedence
   always_comb begin
      if (!in_code && !in_data) begin
         cpu_ok = 1'b1;                       // not a paged region
      end else if (!bus_ok) begin
         cpu_ok = 1'b0;
      end else if (cpu_priv) begin
         cpu_ok = 1'b1;
      end else if (in_code) begin
         cpu_ok = !CPU_WE_I && CPU_PAGE_OK_I;
      end else begin
         cpu_ok = CPU_PAGE_OK_I;
      end
   end

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   always_comb begin
      st_d           = st_q;
      st_d.rvalid    = 1'b0;
      st_d.dma_ack   = DMA_REQ_I;
      st_d.cpu_ack   = CPU_REQ_I;
      // a refused block never sees a start strobe
      st_d.dma_start = DMA_REQ_I && dma_allowed;
      st_d.cpu_grant = CPU_REQ_I && cpu_ok;
      // privileged ids skip translation entirely
      st_d.phys_page = cpu_priv ? cpu_vpage : CPU_MAP_PAGE_I;

      // register writes, privileged ids only
      if (SRP_WR_I && srp_priv) begin
         case (SRP_ADDR_I)
            drg_pkg::DRG_OFS_LOW: begin
               st_d.permit_low = SRP_WDATA_I;
            end
            drg_pkg::DRG_OFS_HIGH: begin
               // upper word bits have no block behind them and drop here
               st_d.permit_high =
                  SRP_WDATA_I[drg_pkg::DRG_HIGH_W-1:0];
            end
            drg_pkg::DRG_OFS_STAT: begin
               st_d.status = st_q.status & ~SRP_WDATA_I[drg_pkg::DRG_ST_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // sticky events after the clear so that a set wins
      if (DMA_REQ_I && !dma_allowed) begin
         st_d.status[drg_pkg::DRG_ST_DMA] = 1'b1;
      end
      if (CPU_REQ_I && !cpu_ok) begin
         st_d.status[drg_pkg::DRG_ST_CPU] = 1'b1;
      end
      if (SRP_WR_I && !srp_priv) begin
         st_d.status[drg_pkg::DRG_ST_WRREF] = 1'b1;
      end

      // reads are open to every id; unmapped offsets read zero
      if (SRP_RD_I) begin
         st_d.rvalid = 1'b1;
         case (SRP_ADDR_I)
            drg_pkg::DRG_OFS_LOW: begin
               st_d.rdata = st_q.permit_low;
            end
            drg_pkg::DRG_OFS_HIGH: begin
               st_d.rdata = {23'h000000, st_q.permit_high};
            end
            drg_pkg::DRG_OFS_STAT: begin
               st_d.rdata = {29'h00000000, st_q.status};
            end
            default: begin
               st_d.rdata = 32'h0000_0000;
            end
         endcase
      end

      if (SRST_I) begin
         st_d             = '0;
         st_d.permit_low  = drg_pkg::DRG_LOW_RST;  // all blocks closed
         st_d.permit_high = drg_pkg::DRG_HIGH_RST;
         st_d.status      = drg_pkg::DRG_ST_RST;
      end
   end

   // ---------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      st_q <= st_d;
   end

   // outputs straight from flip-flops, except DMA_DENY_O gated from two of them
   assign SRP_RDATA_O     = st_q.rdata;
   assign SRP_RVALID_O    = st_q.rvalid;
   assign DMA_ACK_O       = st_q.dma_ack;
   assign DMA_START_O     = st_q.dma_start;
   assign DMA_DENY_O      = st_q.dma_ack && !st_q.dma_start;
   assign CPU_ACK_O       = st_q.cpu_ack;
   assign CPU_GRANT_O     = st_q.cpu_grant;
   assign CPU_PHYS_PAGE_O = st_q.phys_page;

   // ---------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------
   // every answer is registered, so most properties look one edge on
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);

   dma_block_deny_a: assert property (
      DMA_REQ_I && dma_in_range && !dma_allowed
      |=> DMA_ACK_O && DMA_DENY_O && !DMA_START_O)
      else $error("dma to closed block was started");

   dma_never_start_a: assert property (
      DMA_START_O |-> $past(DMA_REQ_I) && $past(dma_allowed))
      else $error("dma start without permission");

   dma_first_bit_a: assert property (
      DMA_REQ_I && DMA_ADDR_I == drg_pkg::DRG_DMA_BASE
      |=> DMA_START_O == $past(st_q.permit_low[0]))
      else $error("first data block not guarded by low bit 0");

   dma_shared_bit_a: assert property (
      DMA_REQ_I && DMA_ADDR_I == 32'h3FFE_0000
      |=> DMA_START_O == $past(st_q.permit_low[25]))
      else $error("shared block not guarded by low bit 25");

   dma_high_bit_a: assert property (
      DMA_REQ_I && DMA_ADDR_I == drg_pkg::DRG_DMA_TOP
      |=> DMA_START_O == $past(st_q.permit_high[8]))
      else $error("top block not guarded by high bit 8");

   permit_lock_a: assert property (
      SRP_WR_I && !srp_priv
      |=> $stable(st_q.permit_low) && $stable(st_q.permit_high))
      else $error("user id changed a permission register");

   permit_load_a: assert property (
      SRP_WR_I && srp_priv && SRP_ADDR_I == drg_pkg::DRG_OFS_LOW
      ##1 SRP_RD_I && SRP_ADDR_I == drg_pkg::DRG_OFS_LOW && !SRP_WR_I
      |=> SRP_RVALID_O && SRP_RDATA_O == $past(SRP_WDATA_I, 2))
      else $error("permit low did not read back written value");

   bus_route_a: assert property (
      CPU_REQ_I && in_code && !CPU_IBUS_I
      |=> CPU_ACK_O && !CPU_GRANT_O)
      else $error("code bank reached over the data bus");

   code_ro_a: assert property (
      CPU_REQ_I && in_code && !cpu_priv && CPU_WE_I
      |=> !CPU_GRANT_O)
      else $error("user id wrote the code bank");

   data_rw_a: assert property (
      CPU_REQ_I && in_data && !CPU_IBUS_I && !cpu_priv && CPU_PAGE_OK_I
      |=> CPU_GRANT_O)
      else $error("granted data page refused to user id");

   priv_full_a: assert property (
      CPU_REQ_I && cpu_priv && bus_ok |=> CPU_GRANT_O)
      else $error("privileged id refused");

   flat_map_a: assert property (
      CPU_REQ_I && cpu_priv |=> CPU_PHYS_PAGE_O == $past(cpu_vpage))
      else $error("privileged page was translated");

   dma_verdict_a: assert property (
      DMA_REQ_I |=> DMA_ACK_O && DMA_START_O == $past(dma_allowed))
      else $error("dma verdict not taken from the permission bit");

   dma_outside_a: assert property (
      DMA_REQ_I && !dma_in_range |=> DMA_START_O)
      else $error("dma outside guarded space was refused");

   deny_logged_a: assert property (
      DMA_REQ_I && !dma_allowed |=> st_q.status[drg_pkg::DRG_ST_DMA])
      else $error("refused dma not logged in status");

   code_read_a: assert property (
      CPU_REQ_I && in_code && CPU_IBUS_I && !cpu_priv && !CPU_WE_I
      && CPU_PAGE_OK_I |=> CPU_GRANT_O)
      else $error("user id could not read its granted code page");

   permit_high_a: assert property (
      SRP_WR_I && srp_priv && SRP_ADDR_I == drg_pkg::DRG_OFS_HIGH
      |=> st_q.permit_high == $past(SRP_WDATA_I[drg_pkg::DRG_HIGH_W-1:0]))
      else $error("permit high did not take a privileged write");

   // watched through reset itself, so the default disable is overridden;
   // a block left open after reset would leak whatever ran before
   reset_closed_a: assert property (disable iff (1'b0)
      SRST_I |=> permit_vec == '0 && !DMA_START_O && !CPU_GRANT_O)
      else $error("reset left a dma block open");

endmodule : drg_guard

// [sim/drg_far_side.sv]
// drg_far_side: dma engine and cpu bus requester facing the guard
// assumes: guard answers on the edge that takes a request, half a cycle after it is driven
`timescale 1ns/1ps
module drg_far_side (
   input  wire logic        clk_i,
   input  wire logic        dma_ack_i,
   input  wire logic        dma_start_i,
   input  wire logic        dma_deny_i,
   input  wire logic        cpu_ack_i,
   input  wire logic        cpu_grant_i,
   input  wire logic [3:0]  cpu_phys_i,
   output logic             dma_req_o,
   output logic [31:0]      dma_addr_o,
   output logic             dma_we_o,
   output logic             cpu_req_o,
   output logic [31:0]      cpu_addr_o,
   output logic             cpu_we_o,
   output logic             cpu_ibus_o,
   output logic [2:0]       cpu_pid_o,
   output logic             cpu_ok_o,
   output logic [3:0]       cpu_map_o
);
   // idle bus at time zero
   initial begin
      {dma_req_o, dma_addr_o, dma_we_o, cpu_req_o, cpu_addr_o} = '0;
      {cpu_we_o, cpu_ibus_o, cpu_pid_o, cpu_ok_o, cpu_map_o} = '0;
   end

   // one dma request; gap idles first so the engine can be slow
   task automatic dma_xfer(input logic [31:0] a, input logic we,
                           input int gap, output logic [2:0] r);
      @(negedge clk_i);
      repeat (gap) @(negedge clk_i);
      dma_req_o  = 1'h1;
      dma_addr_o = a;
      dma_we_o   = we;
      @(negedge clk_i);
      r          = {dma_ack_i, dma_start_i, dma_deny_i};
      dma_req_o  = 1'h0;
      dma_addr_o = ~a;   // released bus must not keep the last address
   endtask : dma_xfer

   // two requests on consecutive edges, no idle cycle between
   task automatic dma_pair(input logic [31:0] a, input logic [31:0] b,
                           output logic [5:0] r);
      @(negedge clk_i);
      dma_req_o  = 1'h1;
      dma_addr_o = a;
      @(negedge clk_i);
      r[5:3]     = {dma_ack_i, dma_start_i, dma_deny_i};
      dma_addr_o = b;
      @(negedge clk_i);
      r[2:0]     = {dma_ack_i, dma_start_i, dma_deny_i};
      dma_req_o  = 1'h0;
      dma_addr_o = ~b;
   endtask : dma_pair

   // one processor access with the page-table verdict beside it
   task automatic cpu_xfer(input logic [31:0] a, input logic ib,
                           input logic we, input logic [2:0] pid,
                           input logic ok, input logic [3:0] map,
                           output logic [5:0] r);
      @(negedge clk_i);
      cpu_req_o  = 1'h1;
      cpu_addr_o = a;
      cpu_ibus_o = ib;
      cpu_we_o   = we;
      cpu_pid_o  = pid;
      cpu_ok_o   = ok;
      cpu_map_o  = map;
      @(negedge clk_i);
      r          = {cpu_ack_i, cpu_grant_i, cpu_phys_i};
      cpu_req_o  = 1'h0;
      cpu_addr_o = ~a;
   endtask : cpu_xfer

endmodule : drg_far_side

// [sim/test_dma_region_guard_and_ram_access_check.sv]
// test bench: permit rows, cpu rows, then reset and awkward cases
// assumes: drg_guard and drg_far_side compiled before this file
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   miscompares++; end end
module test_dma_region_guard_and_ram_access_check;
   typedef struct packed {
      logic [31:0] lo; logic [8:0] hi; logic [31:0] a; logic we; logic st;
   } drg_drow_s;
   typedef struct packed {
      logic [31:0] a; logic ib; logic we; logic [2:0] pid; logic ok;
      logic [3:0] map; logic g; logic [3:0] ph;
   } drg_crow_s;
   logic        clk = 1'h0;
   logic        srst, srp_wr, srp_rd, srp_rvalid;
   logic [7:0]  srp_addr;
   logic [31:0] srp_wdata, srp_rdata, dma_addr, cpu_addr;
   logic [2:0]  srp_pid, cpu_pid, dr;
   logic        dma_req, dma_we, dma_ack, dma_start, dma_deny;
   logic        cpu_req, cpu_we, cpu_ibus, cpu_ok, cpu_ack, cpu_grant;
   logic [3:0]  cpu_map, cpu_phys;
   logic [5:0]  cr, pr;
   int          miscompares = 0;
   int          check_count = 0;
   // --------------------------------------------------------------------
   // rows: permits, address, write, expected start
   // --------------------------------------------------------------------
   drg_drow_s drows [10] = '{
      '{32'h0000_0001, 9'h000, 32'h3FFA_E000, 1'h0, 1'h1},
      '{32'h0000_0001, 9'h000, 32'h3FFB_0000, 1'h1, 1'h0},
      '{32'hFEFF_FFFF, 9'h1FF, 32'h3FFD_E000, 1'h1, 1'h0},
      '{32'h0100_0000, 9'h000, 32'h3FFD_FFFF, 1'h1, 1'h1},
      '{32'h0200_0000, 9'h000, 32'h3FFE_0000, 1'h0, 1'h1},
      '{32'h8000_0000, 9'h000, 32'h3FFE_DFFF, 1'h1, 1'h1},
      '{32'hFFFF_FFFF, 9'h000, 32'h3FFE_E000, 1'h0, 1'h0},
      '{32'h0000_0000, 9'h001, 32'h3FFE_FFFF, 1'h1, 1'h1},
      '{32'h0000_0000, 9'h100, 32'h3FFF_FFFF, 1'h0, 1'h1},
      '{32'h0000_0000, 9'h000, 32'h3FFA_DFFF, 1'h1, 1'h1}};
   drg_crow_s crows [8] = '{
      '{32'h4008_2000, 1'h1, 1'h0, 3'h3, 1'h1, 4'h5, 1'h1, 4'h5},
      '{32'h4008_2000, 1'h1, 1'h1, 3'h3, 1'h1, 4'h5, 1'h0, 4'h0},
      '{32'h3FFC_4000, 1'h0, 1'h1, 3'h7, 1'h1, 4'h9, 1'h1, 4'h9},
      '{32'h3FFC_4000, 1'h0, 1'h0, 3'h2, 1'h0, 4'h9, 1'h0, 4'h0},
      '{32'h4009_E000, 1'h1, 1'h1, 3'h0, 1'h0, 4'h3, 1'h1, 4'hF},
      '{32'h3FFD_E000, 1'h0, 1'h1, 3'h1, 1'h0, 4'h3, 1'h1, 4'hF},
      '{32'h4008_0000, 1'h0, 1'h0, 3'h0, 1'h1, 4'h0, 1'h0, 4'h0},
      '{32'h3FFC_0000, 1'h1, 1'h0, 3'h0, 1'h1, 4'h0, 1'h0, 4'h0}};

   // clock 20 MHz
   always #25 clk = ~clk;

   drg_guard i_dut (.CORE_CLK_I(clk), .SRST_I(srst), .SRP_ADDR_I(srp_addr),
      .SRP_WR_I(srp_wr), .SRP_RD_I(srp_rd), .SRP_WDATA_I(srp_wdata),
      .SRP_PID_I(srp_pid), .SRP_RDATA_O(srp_rdata),
      .SRP_RVALID_O(srp_rvalid), .DMA_REQ_I(dma_req), .DMA_ADDR_I(dma_addr),
      .DMA_WE_I(dma_we), .DMA_ACK_O(dma_ack), .DMA_START_O(dma_start),
      .DMA_DENY_O(dma_deny), .CPU_REQ_I(cpu_req), .CPU_ADDR_I(cpu_addr),
      .CPU_WE_I(cpu_we), .CPU_IBUS_I(cpu_ibus), .CPU_PID_I(cpu_pid),
      .CPU_PAGE_OK_I(cpu_ok), .CPU_MAP_PAGE_I(cpu_map), .CPU_ACK_O(cpu_ack),
      .CPU_GRANT_O(cpu_grant), .CPU_PHYS_PAGE_O(cpu_phys));

   drg_far_side i_far (.clk_i(clk), .dma_ack_i(dma_ack),
      .dma_start_i(dma_start), .dma_deny_i(dma_deny), .cpu_ack_i(cpu_ack),
      .cpu_grant_i(cpu_grant), .cpu_phys_i(cpu_phys), .dma_req_o(dma_req),
      .dma_addr_o(dma_addr), .dma_we_o(dma_we), .cpu_req_o(cpu_req),
      .cpu_addr_o(cpu_addr), .cpu_we_o(cpu_we), .cpu_ibus_o(cpu_ibus),
      .cpu_pid_o(cpu_pid), .cpu_ok_o(cpu_ok), .cpu_map_o(cpu_map));

   // --------------------------------------------------------------------
   // register port tasks and verdict
   // --------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] pid);
      @(negedge clk);
      {srp_wr, srp_addr, srp_wdata, srp_pid} = {1'h1, a, d, pid};
      @(negedge clk);
      srp_wr    = 1'h0;
      srp_wdata = ~d;   // data lines do not hold the last word
   endtask : wr

   // read one word and compare it with rvalid
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk);
      {srp_rd, srp_addr} = {1'h1, a};
      @(negedge clk);
      `CHK("reg read", {1'h1, e}, {srp_rvalid, srp_rdata})
      srp_rd = 1'h0;
   endtask : rd

   task automatic final_report;
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      repeat (4000) @(posedge clk);
      miscompares++;
      final_report();
   end

   // main sequence
   initial begin
      {srst, srp_wr, srp_rd, srp_addr, srp_wdata, srp_pid} = {1'h1, 45'h0};
      repeat (6) @(negedge clk);
      srst = 1'h0;
      foreach (drows[i]) begin
         wr(8'h00, drows[i].lo, 3'(i % 2));
         wr(8'h04, {23'h0, drows[i].hi}, 3'h1);
         i_far.dma_xfer(drows[i].a, drows[i].we, i % 3, dr);
         `CHK("dma", {1'h1, drows[i].st, ~drows[i].st}, dr)
      end
      foreach (crows[i]) begin
         i_far.cpu_xfer(crows[i].a, crows[i].ib, crows[i].we, crows[i].pid,
                        crows[i].ok, crows[i].map, cr);
         `CHK("cpu grant", {1'h1, crows[i].g}, cr[5:4])
         if (crows[i].g) `CHK("cpu page", crows[i].ph, cr[3:0])
      end
      // reset in mid-run closes every block again
      @(negedge clk);
      srst = 1'h1;
      @(negedge clk);
      srst = 1'h0;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      i_far.dma_xfer(32'h3FFA_E000, 1'h0, 0, dr);
      `CHK("dma closed", 3'h5, dr)
      wr(8'h00, 32'hFFFF_FFFF, 3'h5);
      rd(8'h00, 32'h0);
      wr(8'h04, 32'hFFFF_FFFF, 3'h1);
      rd(8'h04, 32'h0000_01FF);
      rd(8'h0C, 32'h0);
      // write then read on the very next edge sees the new word
      @(negedge clk);
      {srp_wr, srp_addr, srp_pid} = {1'h1, 8'h00, 3'h1};
      srp_wdata = 32'hA5A5_A5A5;
      @(negedge clk);
      {srp_wr, srp_rd} = 2'h1;
      @(negedge clk);
      `CHK("read back", 33'h1_A5A5_A5A5, {srp_rvalid, srp_rdata})
      srp_rd = 1'h0;
      // an unmapped offset must not land in the low permit word
      wr(8'h0C, 32'h0, 3'h0);
      rd(8'h00, 32'hA5A5_A5A5);
      wr(8'h00, 32'h0000_0001, 3'h0);
      i_far.dma_pair(32'h3FFA_E000, 32'h3FFB_0000, pr);
      `CHK("dma pair", 6'h35, pr)
      i_far.cpu_xfer(32'h4008_0000, 1'h1, 1'h1, 3'h4, 1'h1, 4'h0, cr);
      `CHK("code write", 2'h2, cr[5:4])
      rd(8'h08, 32'h7);
      wr(8'h08, 32'h7, 3'h0);
      rd(8'h08, 32'h0);
      final_report();
   end
endmodule : test_dma_region_guard_and_ram_access_check
